// >>> rtl/epw_pkg.sv
// Purpose: shared constants and types for the enabled pulse width modulator
// Assumes: 20 MHz system clock, AHB-Lite register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package epw_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICKS_PER_UNIT = 10;
	localparam logic [15:0] PERIOD_MIN = 16'h0001;
	localparam logic [15:0] PERIOD_MAX = 16'h7fff;
	localparam logic [15:0] PERIOD_RST = 16'h000a;
	localparam logic [6:0] DUTY_MAX = 7'h64;
	localparam logic [6:0] DUTY_RST = 7'h00;
	localparam int ANA_CH = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PERIOD = 8'h04;
	localparam logic [7:0] A_DUTY = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_CUR = 8'h10;
	localparam logic [1:0] SRC_CONST = 2'h0;
	localparam logic [1:0] SRC_ANALOG = 2'h1;
	localparam logic [1:0] SRC_BLOCK = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef struct packed {
		logic [1:0] src;
		logic [2:0] chan;
	} epw_sel_t;
	typedef struct packed {
		logic [15:0] set_period;
		logic [23:0] cur_period;
	} epw_words_t;
endpackage

// >>> rtl/epw_tick.sv
// Purpose: 10 ms time base for the modulator
// Assumes: clk at the package rate, synchronous active-high reset
// Notes: tick is a one-cycle pulse every TICK_CYCLES enabled cycles
`timescale 1ns/1ns
module epw_tick #(
	parameter int CYCLES = epw_pkg::TICK_CYCLES
) (
	// clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// time base
	output logic tick
);
	import epw_pkg::*;
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic next_tick;
	always_comb
	begin
		next_cnt = cnt + 24'h000001;
		next_tick = 1'b0;
		if (cnt == 24'(CYCLES - 1))
		begin
			next_cnt = 24'h000000;
			next_tick = 1'b1;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= 24'h000000;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// >>> rtl/epw_pwm.sv
// Purpose: enabled pulse width modulator with an AHB-Lite register slave
// Assumes: single clock, synchronous active-high reset, word accesses only
// Notes: period in 100 ms units, duty 0..100 percent, 10 ms steps
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module epw_pwm #(
	parameter int TICK_CYC = epw_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// enable pin (asynchronous)
	input wire logic enable_pin,
	// duty sources: analog channels in tenths of a percent, block word
	input wire logic [epw_pkg::ANA_CH*12-1:0] analog_in,
	input wire logic [15:0] block_word_duty_source,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// outputs
	output logic pwm_out,
	output epw_pkg::epw_words_t words
);
	import epw_pkg::*;

	// clamp a percentage, derived from a 0.1 % word, to 0..100
	function automatic logic [6:0] pct(input logic [15:0] tenths);
		logic [15:0] p;
		p = tenths / 16'd10;
		pct = (p > 16'(DUTY_MAX)) ? DUTY_MAX : p[6:0];
	endfunction

	// a period word is taken only if bits 15:0 lie inside 1..32767; upper bits are ignored
	function automatic logic period_ok(input logic [31:0] w);
		period_ok = w[15:0] >= PERIOD_MIN && w[15:0] <= PERIOD_MAX;
	endfunction

	// a duty word above 100 percent is ignored as a whole
	function automatic logic duty_ok(input logic [31:0] w);
		duty_ok = w[6:0] <= DUTY_MAX && w[31:7] == '0;
	endfunction

	logic tick;
	epw_tick #(.CYCLES(TICK_CYC)) u_tick (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.tick(tick)
	);

	// enable pin synchroniser; only en_s2 is read by logic
	logic en_s1, en_s2;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
		end
		else if (ce)
		begin
			en_s1 <= enable_pin;
			en_s2 <= en_s1;
		end
	end

	// register state
	logic [15:0] period, next_period;
	logic [6:0] duty_const, next_duty_const;
	epw_sel_t sel, next_sel;
	logic ap_wr, ap_rd, next_ap_wr, next_ap_rd;
	logic [7:0] ap_addr, next_ap_addr;
	logic [31:0] next_hrdata;

	// counter state
	logic [23:0] cnt, next_cnt;
	logic next_pwm;
	logic [6:0] duty;
	logic [23:0] period_ticks, on_ticks;

	// duty source select
	always_comb
	begin
		case (sel.src)
			SRC_CONST: duty = duty_const;
			SRC_ANALOG: duty = pct(16'(analog_in[sel.chan*12 +: 12]));
			SRC_BLOCK: duty = pct(block_word_duty_source);
			default: duty = duty_const;
		endcase
	end

	// tick counts: 100 ms units and 10 ms steps
	assign period_ticks = 24'(period) * 24'(TICKS_PER_UNIT);
	assign on_ticks = 24'((32'(period_ticks) * 32'(duty)) / 32'(DUTY_MAX));

	always_comb
	begin
		next_cnt = cnt;
		if (!en_s2)
			next_cnt = 24'h000000;
		else if (tick)
			next_cnt = (cnt >= period_ticks - 24'h000001) ? 24'h000000
				: cnt + 24'h000001;
		next_pwm = en_s2 && (next_cnt < on_ticks);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= 24'h000000;
			pwm_out <= 1'b0;
			words <= '0;
		end
		else if (ce)
		begin
			cnt <= next_cnt;
			pwm_out <= next_pwm;
			words.set_period <= period;
			words.cur_period <= next_cnt;
		end
	end

	// bus slave: address phase captured, data phase completes next cycle
	// hreadyout never drops, so the bus must stay idle while ce is low:
	// a transfer offered then would be lost without a wait state
	always_comb
	begin
		next_period = period;
		next_duty_const = duty_const;
		next_sel = sel;
		next_hrdata = hrdata;
		next_ap_wr = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
		next_ap_rd = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
		next_ap_addr = haddr[7:0];
		if (ap_wr)
		begin
			case (ap_addr)
				A_CTRL: next_sel = epw_sel_t'(hwdata[4:0]);
				A_PERIOD:
					if (period_ok(hwdata))
						next_period = hwdata[15:0];
				A_DUTY:
					if (duty_ok(hwdata))
						next_duty_const = hwdata[6:0];
				default: ;
			endcase
		end
		if (next_ap_rd)
		begin
			case (haddr[7:0])
				A_CTRL: next_hrdata = {27'h0, sel};
				A_PERIOD: next_hrdata = {16'h0, period};
				A_DUTY: next_hrdata = {25'h0, duty_const};
				A_STATUS: next_hrdata = {23'h0, duty, en_s2, pwm_out};
				A_CUR: next_hrdata = {8'h0, cnt};
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			period <= PERIOD_RST;
			duty_const <= DUTY_RST;
			sel <= '{src: SRC_CONST, chan: 3'h0};
			ap_wr <= 1'b0;
			ap_rd <= 1'b0;
			ap_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			period <= next_period;
			duty_const <= next_duty_const;
			sel <= next_sel;
			ap_wr <= next_ap_wr;
			ap_rd <= next_ap_rd;
			ap_addr <= next_ap_addr;
			hrdata <= next_hrdata;
		end
	end

	// assertions
	off_when_disabled_a: assert property (@(posedge clk) disable iff (rst)
		ce && !en_s2 |=> !pwm_out)
		else $error("output on while disabled");
	count_restart_a: assert property (@(posedge clk) disable iff (rst)
		ce && !en_s2 |=> cnt == 24'h000000)
		else $error("count not cleared while disabled");
	count_bound_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && tick |=> cnt < period_ticks || $changed(period))
		else $error("count beyond period");
	step_only_tick_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && !tick |=> $stable(cnt))
		else $error("count moved without tick");
	duty_zero_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && duty == 7'h00 |=> !pwm_out)
		else $error("output on at zero duty");
	duty_full_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && duty == DUTY_MAX && $stable(duty) &&
		cnt < period_ticks |=> pwm_out)
		else $error("output off at full duty");
	period_range_a: assert property (@(posedge clk) disable iff (rst)
		period >= PERIOD_MIN && period <= PERIOD_MAX)
		else $error("period out of range");
	duty_range_a: assert property (@(posedge clk) disable iff (rst)
		duty_const <= DUTY_MAX)
		else $error("constant duty out of range");
	words_track_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> words.set_period == $past(period))
		else $error("set period word stale");
	on_width_a: assert property (@(posedge clk) disable iff (rst)
		on_ticks <= period_ticks)
		else $error("on time exceeds period");

	// counter stepping
	wrap_zero_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && tick && cnt >= period_ticks - 24'h000001
		|=> cnt == 24'h000000)
		else $error("count did not wrap");
	step_one_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && tick && cnt < period_ticks - 24'h000001
		|=> cnt == $past(cnt) + 24'h000001)
		else $error("count did not step by one");
	pulse_start_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && tick && cnt >= period_ticks - 24'h000001 &&
		on_ticks != 24'h000000 |=> pwm_out)
		else $error("period did not start on");
	pulse_end_a: assert property (@(posedge clk) disable iff (rst)
		ce && en_s2 && tick && cnt < period_ticks - 24'h000001 &&
		cnt + 24'h000001 == on_ticks |=> !pwm_out)
		else $error("output on past its width");
	restart_zero_a: assert property (@(posedge clk) disable iff (rst)
		ce && $rose(en_s2) |-> cnt == 24'h000000)
		else $error("count did not restart from zero");
	tick_single_a: assert property (@(posedge clk) disable iff (rst)
		ce && tick |=> !tick)
		else $error("time base tick longer than one cycle");
	cur_word_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> words.cur_period == cnt)
		else $error("current period word stale");
	duty_clamp_a: assert property (@(posedge clk) disable iff (rst)
		duty <= DUTY_MAX)
		else $error("effective duty above full scale");

	// register bus
	period_refuse_a: assert property (@(posedge clk) disable iff (rst)
		ce && ap_wr && ap_addr == A_PERIOD && !period_ok(hwdata)
		|=> $stable(period))
		else $error("out of range period taken");
	duty_refuse_a: assert property (@(posedge clk) disable iff (rst)
		ce && ap_wr && ap_addr == A_DUTY && !duty_ok(hwdata)
		|=> $stable(duty_const))
		else $error("out of range duty taken");
	duty_write_a: assert property (@(posedge clk) disable iff (rst)
		ce && ap_wr && ap_addr == A_DUTY && duty_ok(hwdata)
		|=> duty_const == $past(hwdata[6:0]))
		else $error("constant duty write lost");
	sel_write_a: assert property (@(posedge clk) disable iff (rst)
		ce && ap_wr && ap_addr == A_CTRL
		|=> sel == epw_sel_t'($past(hwdata[4:0])))
		else $error("source select write lost");
	read_period_a: assert property (@(posedge clk) disable iff (rst)
		ce && hsel && hready && htrans == HTRANS_NONSEQ && !hwrite &&
		haddr[7:0] == A_PERIOD |=> hrdata == {16'h0000, $past(period)})
		else $error("period read wrong");
	read_cur_a: assert property (@(posedge clk) disable iff (rst)
		ce && hsel && hready && htrans == HTRANS_NONSEQ && !hwrite &&
		haddr[7:0] == A_CUR |=> hrdata == {8'h00, $past(cnt)})
		else $error("current count read wrong");
	bus_okay_a: assert property (@(posedge clk) disable iff (rst)
		hreadyout && !hresp)
		else $error("bus response not okay");

	wrap_cov: cover property (@(posedge clk) disable iff (rst)
		en_s2 && tick && cnt == period_ticks - 24'h000001);
	pulse_cov: cover property (@(posedge clk) disable iff (rst)
		!pwm_out ##1 pwm_out);
	disable_cov: cover property (@(posedge clk) disable iff (rst)
		en_s2 ##1 !en_s2);
	analog_cov: cover property (@(posedge clk) disable iff (rst)
		sel.src == SRC_ANALOG && pwm_out);
	full_cov: cover property (@(posedge clk) disable iff (rst)
		en_s2 && duty == DUTY_MAX && pwm_out);
endmodule

// >>> tb/epw_load.sv
// Purpose: load switched by the modulator output
// Assumes: one clock, load on while drive is high
// Notes: counts on cycles so duty is judged over whole periods
`timescale 1ns/1ns
module epw_load (
	// clock and control
	input wire logic clk,
	input wire logic clr,
	// switched line
	input wire logic drive,
	output int on_cyc
);
	always_ff @(posedge clk)
		on_cyc <= clr ? 0 : on_cyc + int'(drive === 1'b1);
endmodule

// >>> tb/epw_pwm_bench.sv
// Purpose: bench for the enabled pulse width modulator
// Assumes: tick shortened to 20 cycles, bus always ready
// Notes: widths are taken from a pulse that starts a fresh period
`timescale 1ns/1ns
module epw_pwm_bench;
	import epw_pkg::*;
	localparam int TC = 20;
	logic clk, rst, en, hsel, hwrite, clr, hrdy, hresp, pwm;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [95:0] ana;
	logic [15:0] bw;
	epw_words_t words;
	int on_cyc, failures, checked;
	epw_pwm #(.TICK_CYC(TC)) dut_u (.clk(clk), .rst(rst), .ce(1'b1),
		.enable_pin(en), .analog_in(ana), .block_word_duty_source(bw),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
		.hreadyout(hrdy), .hresp(hresp), .pwm_out(pwm), .words(words));
	epw_load load_u (.clk(clk), .clr(clr), .drive(pwm), .on_cyc(on_cyc));
	task close_out;
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (hrdy !== 1'b1 && i < 50);
		if (hrdy !== 1'b1)
		begin
			failures++;
			close_out;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task till(input logic v);
		int i;
		for (i = 0; i < 3000 && pwm !== v; i++)
			@(posedge clk);
		if (pwm !== v)
		begin
			failures++;
			close_out;
		end
	endtask
	task width(input string n, input int e);
		int c;
		c = 0;
		// skip any pulse cut short by enable or a duty change
		till(1'b1);
		till(1'b0);
		till(1'b1);
		while (pwm === 1'b1 && c < 3000)
		begin
			@(posedge clk);
			c++;
		end
		chk(n, e, c);
	endtask
	// whole periods only, so the phase of the window does not matter
	task win(input string n, input int e);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (400) @(posedge clk);
		#1 chk(n, e, on_cyc);
	endtask
	task regs_reset;
		xfer(1'b0, A_PERIOD, 32'h0);
		chk("period", {16'h0, PERIOD_RST}, r);
		xfer(1'b0, A_CTRL, 32'h0);
		chk("ctrl", 32'h0, r);
		xfer(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h0, r);
		xfer(1'b1, A_PERIOD, 32'h0);
		xfer(1'b1, A_DUTY, 32'h65);
		xfer(1'b1, A_PERIOD, 32'h8000);
		xfer(1'b0, A_PERIOD, 32'h0);
		chk("period_bad", {16'h0, PERIOD_RST}, r);
		xfer(1'b0, A_DUTY, 32'h0);
		chk("duty", {25'h0, DUTY_RST}, r);
		xfer(1'b1, A_PERIOD, {16'h0, PERIOD_MAX});
		xfer(1'b0, A_PERIOD, 32'h0);
		chk("period_max", 32'h7fff, r);
	endtask
	task const_duty;
		xfer(1'b1, A_PERIOD, 32'h1);
		xfer(1'b1, A_DUTY, 32'h1e);
		en <= 1'b1;
		width("p1d30", 3 * TC);
		win("on_p1d30", 120);
		chk("set_per", 32'h1, {16'h0, words.set_period});
		chk("cur_per", 32'h1, {31'h0, words.cur_period < 24'd10});
		xfer(1'b1, A_PERIOD, 32'h2);
		width("p2d30", 6 * TC);
		xfer(1'b1, A_DUTY, 32'h0);
		repeat (400) @(posedge clk);
		win("on_d0", 0);
		xfer(1'b1, A_DUTY, 32'h64);
		win("on_d100", 400);
	endtask
	task sources;
		ana[7*12+:12] <= 12'h1f4;
		xfer(1'b1, A_CTRL, 32'h0f);
		width("analog7", 10 * TC);
		bw <= 16'h00c8;
		xfer(1'b1, A_CTRL, 32'h10);
		width("block", 4 * TC);
		xfer(1'b0, A_STATUS, 32'h0);
		chk("status", 32'h29, {1'b0, r[31:1]});
	endtask
	task gate_off;
		en <= 1'b0;
		repeat (5) @(posedge clk);
		chk("off", 32'h0, {31'h0, pwm});
		chk("cnt0", 32'h0, {8'h0, words.cur_period});
		xfer(1'b0, A_CUR, 32'h0);
		chk("cur_reg", 32'h0, r);
		en <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("restart", 32'h1, {31'h0, pwm});
	endtask
	initial
	begin
		{rst, en, hsel, hwrite, clr} = 5'h10;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		ana = 96'h0;
		bw = 16'h0;
		failures = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		regs_reset;
		const_duty;
		sources;
		gate_off;
		close_out;
	end
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		close_out;
	end
endmodule
